// ---- hw/isa_host_defs.svh ----
// Constants for the ISA host-bus front end.
`ifndef ISA_HOST_DEFS_SVH
`define ISA_HOST_DEFS_SVH
`define IO_SEQ_INDEX     16'h03C4
`define IO_GFX_INDEX     16'h03CE
`define IO_CRT_MONO      16'h03B4
`define IO_CRT_COLOR     16'h03D4
`define IO_STAT_MONO     16'h03BA
`define IO_STAT_COLOR    16'h03DA
`define MEM_A000_TOP7    7'h05
`define MEM_B000_PAGE    4'h0B
`define BIOS_TOP7        7'h06
`define MODE_TEXT_COLOR  2'h1
`define MODE_TEXT_MONO   2'h2
`define SOLE_ADAPTER_BIT 6
`define IRQ_CLEAR_BIT    4
`define IRQ_ENABLE_N_BIT 5
`define VRETRACE_END_IDX 8'h11
`define SEQ_MODE_IDX     8'h08
`endif

// ---- hw/isa_host_pkg.sv ----
// Types shared by the ISA host-bus front end.
package isa_host_pkg;
  typedef enum logic [1:0] {BUS_ISA, BUS_LOCAL_SX, BUS_LOCAL_DX, BUS_LOCAL_32} bus_type_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic        io_wr_n;
    logic        mem_rd_n;
    logic        mem_wr_n;
    logic        refresh_n;
  } isa_pins_t;
  typedef struct packed {
    logic [1:0] s_iow;
    logic [1:0] s_memr;
    logic [1:0] s_memw;
    logic [1:0] s_ref;
    logic       iow_q;
    logic       memw_q;
    logic       memr_q;
    logic [7:0] seq_index;
    logic [7:0] crt_index;
    logic [7:0] seq_mode;
    logic [7:0] vretrace_end_ctrl_reg;
    logic [15:0] wr_latch_data;
    logic [23:0] wr_latch_addr;
    logic        wr_pending;
    logic        rd_ready;
    logic        irq_pending;
    bus_type_t   bus_type;
  } state_t;
endpackage

// ---- hw/isa_host_bus_interface.sv ----
// ISA host-bus front end: I/O writes, memory strobes, size decode and strap capture.
// Operation
// RULE_01: I/O write in range stores data at IOW rising edge.
// RULE_02: Sixteen-bit I/O write carries index on low lane, data on high.
// RULE_03: Three-state interrupt output controlled by vertical-retrace-end control register.
// RULE_04: MEMCS16 open-collector low when a 16-bit memory access is decoded.
// RULE_05: Memory decode by display mode range, only with sole-adapter enable high.
// RULE_06: Memory reads during refresh are ignored.
// RULE_07: Reset high floats all outputs and loads register reset values.
// RULE_08: Host holds SMEMR low for the whole read transfer.
// RULE_09: BIOS select low while SMEMR low and address in BIOS region.
// RULE_10: Memory write data latched at SMEMW rising edge, moved to memory later.
// RULE_11: Straps choose host-bus type when configuration strap is low.
// RULE_12: Ready low at read start, high when data ready, then floated.
// RULE_13: Sixteen-bit I/O claim only for the listed register pairs.
// RULE_14: Host strobes pass a two-flop synchroniser before their edges are used.
`include "isa_host_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module isa_host_bus_interface
  import isa_host_pkg::*;
(
  input  wire logic                    I_REF_CLK,
  input  wire logic                    I_RESET_N,
  input  wire logic                    i_reset,
  input  wire isa_host_pkg::isa_pins_t i_pins,
  input  wire logic                    i_bus_type_strap0,
  input  wire logic                    i_bus_type_strap1,
  input  wire logic                    i_bus_config_strap_n,
  input  wire logic                    i_vretrace,
  input  wire logic                    i_mem_wr_done,
  input  wire logic                    i_mem_rd_valid,
  output logic [1:0]                   o_display_mode,
  output logic                         o_mem_wr_req,
  output logic [23:0]                  o_mem_wr_addr,
  output logic [15:0]                  o_mem_wr_data,
  output logic                         o_mem_rd_req,
  output logic                         o_irq,
  output logic                         o_irq_oe,
  output logic                         o_bus_size16_n,
  output logic                         o_bus_size16_oe,
  output logic                         o_io16_claim_n,
  output logic                         o_io16_claim_oe,
  output logic                         o_bios_rom_select_n,
  output logic                         o_bios_rom_select_oe,
  output logic                         o_ready,
  output logic                         o_ready_oe,
  output isa_host_pkg::bus_type_t      o_bus_type
);
  import isa_host_pkg::*;

  state_t st;
  state_t next_st;
  logic   iow_rise;
  logic   memw_rise;
  logic   memr_act;
  logic   io_hit;
  logic   mem16_hit;
  logic   bios_hit;
  logic   sole_adapter_enable;
  logic   outputs_on;
  logic [15:0] io_addr;

  // The address and data buses are assumed stable around strobe edges, so only strobes are synchronised.
  assign iow_rise  = st.s_iow[1] & ~st.iow_q;            // [RULE_14]
  assign memw_rise = st.s_memw[1] & ~st.memw_q;          // [RULE_14]
  assign memr_act  = ~st.s_memr[1] & st.s_ref[1];        // [RULE_06]
  assign io_addr   = i_pins.addr[15:0];
  assign sole_adapter_enable = st.seq_mode[`SOLE_ADAPTER_BIT];
  assign o_display_mode = st.seq_mode[1:0];
  assign outputs_on = ~i_reset;                          // [RULE_07]

  always_comb begin
    io_hit = 1'b0;
    if ({io_addr[15:1], 1'b0} == `IO_SEQ_INDEX) begin      // [RULE_13]
      io_hit = 1'b1;
    end else if ({io_addr[15:1], 1'b0} == `IO_GFX_INDEX) begin
      io_hit = 1'b1;
    end else if ({io_addr[15:1], 1'b0} == `IO_CRT_MONO || {io_addr[15:1], 1'b0} == `IO_CRT_COLOR) begin
      io_hit = 1'b1;
    end else if (io_addr == `IO_STAT_MONO || io_addr == `IO_STAT_COLOR) begin
      io_hit = 1'b1;
    end
  end

  always_comb begin
    mem16_hit = 1'b0;
    if (!sole_adapter_enable) begin                       // [RULE_05]
      mem16_hit = 1'b0;
    end else if (o_display_mode == `MODE_TEXT_COLOR) begin
      // The upper lines are compared too, so an alias above the first megabyte is never claimed.
      mem16_hit = (i_pins.addr[23:16] == {4'h0, `MEM_B000_PAGE}) && i_pins.addr[15];
    end else if (o_display_mode == `MODE_TEXT_MONO) begin
      mem16_hit = (i_pins.addr[23:16] == {4'h0, `MEM_B000_PAGE}) && !i_pins.addr[15];
    end else begin
      mem16_hit = (i_pins.addr[23:17] == `MEM_A000_TOP7);
    end
  end
  assign bios_hit = (i_pins.addr[23:17] == `BIOS_TOP7);

  always_comb begin
    next_st = st;
    next_st.s_iow  = {st.s_iow[0], i_pins.io_wr_n};       // [RULE_14]
    next_st.s_memr = {st.s_memr[0], i_pins.mem_rd_n};
    next_st.s_memw = {st.s_memw[0], i_pins.mem_wr_n};
    next_st.s_ref  = {st.s_ref[0], i_pins.refresh_n};
    next_st.iow_q  = st.s_iow[1];
    next_st.memw_q = st.s_memw[1];
    next_st.memr_q = memr_act;
    if (iow_rise && io_hit) begin                        // [RULE_01]
      if (io_addr[0] == 1'b0) begin
        if ({io_addr[15:1], 1'b0} == `IO_SEQ_INDEX) begin
          next_st.seq_index = i_pins.data[7:0];          // [RULE_02]
          if (i_pins.data[7:0] == `SEQ_MODE_IDX) begin
            next_st.seq_mode = i_pins.data[15:8];
          end
        end else if ({io_addr[15:1], 1'b0} == `IO_CRT_MONO || {io_addr[15:1], 1'b0} == `IO_CRT_COLOR) begin
          next_st.crt_index = i_pins.data[7:0];          // [RULE_02]
          if (i_pins.data[7:0] == `VRETRACE_END_IDX) begin
            next_st.vretrace_end_ctrl_reg = i_pins.data[15:8];
          end
        end
      end else if ({io_addr[15:1], 1'b0} == `IO_SEQ_INDEX && st.seq_index == `SEQ_MODE_IDX) begin
        next_st.seq_mode = i_pins.data[7:0];
      end else if (({io_addr[15:1], 1'b0} == `IO_CRT_MONO || {io_addr[15:1], 1'b0} == `IO_CRT_COLOR)
                   && st.crt_index == `VRETRACE_END_IDX) begin
        next_st.vretrace_end_ctrl_reg = i_pins.data[7:0];
      end
    end
    // Clearing the control bit holds the request low; a new retrace only sets it again once released.
    if (!st.vretrace_end_ctrl_reg[`IRQ_CLEAR_BIT]) begin  // [RULE_03]
      next_st.irq_pending = 1'b0;
    end else if (i_vretrace) begin
      next_st.irq_pending = 1'b1;
    end
    if (st.wr_pending && i_mem_wr_done) begin
      next_st.wr_pending = 1'b0;
    end
    if (memw_rise && mem16_hit) begin                    // [RULE_10]
      next_st.wr_latch_data = i_pins.data;
      next_st.wr_latch_addr = i_pins.addr;
      next_st.wr_pending    = 1'b1;
    end
    if (!memr_act) begin
      next_st.rd_ready = 1'b0;
    end else if (i_mem_rd_valid) begin                    // [RULE_12]
      next_st.rd_ready = 1'b1;
    end
    // Straps are re-sampled every cycle and are expected to stay static.
    if (!i_bus_config_strap_n) begin                      // [RULE_11]
      case ({i_bus_type_strap1, i_bus_type_strap0})
        2'b01:   next_st.bus_type = BUS_LOCAL_SX;
        2'b10:   next_st.bus_type = BUS_LOCAL_DX;
        2'b11:   next_st.bus_type = BUS_LOCAL_32;
        default: next_st.bus_type = BUS_ISA;
      endcase
    end else begin
      next_st.bus_type = BUS_ISA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N || i_reset) begin                      // [RULE_07]
      st <= '0;
      st.s_iow <= 2'b11;
      st.s_memr <= 2'b11;
      st.s_memw <= 2'b11;
      st.s_ref <= 2'b11;
      st.iow_q <= 1'b1;
      st.memw_q <= 1'b1;
      st.bus_type <= BUS_ISA;
    end else begin
      st <= next_st;
    end
  end

  assign o_bus_type    = st.bus_type;
  assign o_mem_wr_req  = st.wr_pending;
  assign o_mem_wr_addr = st.wr_latch_addr;
  assign o_mem_wr_data = st.wr_latch_data;
  assign o_mem_rd_req  = memr_act && mem16_hit && !st.rd_ready;
  assign o_irq         = st.irq_pending;
  assign o_irq_oe      = outputs_on && !st.vretrace_end_ctrl_reg[`IRQ_ENABLE_N_BIT]; // [RULE_03]
  assign o_bus_size16_n  = 1'b0;
  assign o_bus_size16_oe = outputs_on && mem16_hit;       // [RULE_04]
  assign o_io16_claim_n  = 1'b0;
  assign o_io16_claim_oe = outputs_on && io_hit;          // [RULE_13]
  assign o_bios_rom_select_n  = ~(memr_act && bios_hit);  // [RULE_09]
  assign o_bios_rom_select_oe = outputs_on;
  assign o_ready    = st.rd_ready;                        // [RULE_12]
  assign o_ready_oe = outputs_on && memr_act && mem16_hit;

  property p_ready_low_start;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      memr_act && !st.memr_q && mem16_hit |-> o_ready_oe && !o_ready;
  endproperty
  a_ready_low_start: assert property (p_ready_low_start) else $error("ready not low at read start"); // [RULE_12]

  property p_ready_float;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      !memr_act |-> !o_ready_oe;
  endproperty
  a_ready_float: assert property (p_ready_float) else $error("ready driven outside read"); // [RULE_12]

  property p_refresh_ignore;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      !st.s_ref[1] |-> o_bios_rom_select_n && !o_mem_rd_req;
  endproperty
  a_refresh_ignore: assert property (p_refresh_ignore) else $error("read honoured in refresh"); // [RULE_06]

  property p_bios_sel;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      !st.s_memr[1] && st.s_ref[1] && bios_hit |-> !o_bios_rom_select_n;
  endproperty
  a_bios_sel: assert property (p_bios_sel) else $error("bios select missing"); // [RULE_09]

  property p_wr_latch;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      memw_rise && mem16_hit |=> o_mem_wr_req && o_mem_wr_data == $past(i_pins.data);
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("write latch not loaded"); // [RULE_10]

  property p_sole_adapter;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      !sole_adapter_enable |-> !o_bus_size16_oe;
  endproperty
  a_sole_adapter: assert property (p_sole_adapter) else $error("size16 without sole adapter"); // [RULE_05]

  property p_io16;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      o_io16_claim_oe |-> io_addr[15:8] == 8'h03;
  endproperty
  a_io16: assert property (p_io16) else $error("io16 claim out of range"); // [RULE_13]

  property p_sync_edge;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N || i_reset)
      iow_rise |-> $past(i_pins.io_wr_n, 2) && !$past(i_pins.io_wr_n, 3);
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("write edge not synchronised"); // [RULE_14]
endmodule
`default_nettype wire

// ---- sim/isa_host_model.sv ----
// ISA host model: places addresses and drives the bus strobes of the front end.
`timescale 1ns/1ns
`default_nettype none
module isa_host_model
  import isa_host_pkg::*;
(
  input  wire logic                   i_clk,
  output var isa_host_pkg::isa_pins_t o_pins
);
  initial o_pins = {24'h00_0000, 16'hffff, 4'hf};
  task automatic place(input logic [23:0] a);
    @(negedge i_clk);
    o_pins.addr = a;
  endtask
  // Each strobe level lasts four clocks or more, so the synchroniser sees both levels.
  task automatic write(input logic mem, input logic [23:0] a, input logic [15:0] d);
    place(a);
    o_pins.data = d;
    o_pins.io_wr_n = mem;
    o_pins.mem_wr_n = !mem;
    repeat (4) @(negedge i_clk);
    o_pins.io_wr_n = 1'h1;
    o_pins.mem_wr_n = 1'h1;
    repeat (6) @(negedge i_clk);
    // Released lines show the inverse, so a late sample cannot pass by luck.
    o_pins.data = ~d;
  endtask
  task automatic read_open(input logic [23:0] a, input logic refresh_n);
    place(a);
    o_pins.refresh_n = refresh_n;
    o_pins.mem_rd_n = 1'h0;
  endtask
  task automatic read_close();
    @(negedge i_clk);
    o_pins.mem_rd_n = 1'h1;
    o_pins.refresh_n = 1'h1;
  endtask
endmodule
`default_nettype wire

// ---- sim/test_isa_host_bus_interface.sv ----
// Self-checking bench for the ISA host-bus front end.
`timescale 1ns/1ns
`default_nettype none
module test_isa_host_bus_interface;
  import isa_host_pkg::*;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        dev_reset = 1'h0;
  logic        strap0 = 1'h0;
  logic        strap1 = 1'h0;
  logic        conf_n = 1'h1;
  logic        vretrace = 1'h0;
  logic        wr_done = 1'h0;
  logic        rd_valid = 1'h0;
  isa_pins_t   pins;
  logic [1:0]  disp_mode;
  logic        wr_req, rd_req, irq, irq_oe, size16_n, size16_oe, claim_n, claim_oe, bios_n, bios_oe, ready, ready_oe;
  logic [23:0] wr_addr;
  logic [15:0] wr_data;
  bus_type_t   bus_type;
  int          err_count = 0;
  int          checks_done = 0;

  isa_host_model i_host (.i_clk(clk), .o_pins(pins));
  isa_host_bus_interface i_dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .i_reset(dev_reset), .i_pins(pins),
    .i_bus_type_strap0(strap0), .i_bus_type_strap1(strap1), .i_bus_config_strap_n(conf_n),
    .i_vretrace(vretrace), .i_mem_wr_done(wr_done), .i_mem_rd_valid(rd_valid), .o_display_mode(disp_mode),
    .o_mem_wr_req(wr_req), .o_mem_wr_addr(wr_addr), .o_mem_wr_data(wr_data), .o_mem_rd_req(rd_req),
    .o_irq(irq), .o_irq_oe(irq_oe), .o_bus_size16_n(size16_n), .o_bus_size16_oe(size16_oe),
    .o_io16_claim_n(claim_n), .o_io16_claim_oe(claim_oe), .o_bios_rom_select_n(bios_n),
    .o_bios_rom_select_oe(bios_oe), .o_ready(ready), .o_ready_oe(ready_oe), .o_bus_type(bus_type));

  always #2 clk = ~clk;

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic io16(input logic [15:0] port, input logic [7:0] idx, input logic [7:0] val);
    i_host.write(1'h0, {8'h00, port}, {val, idx});
  endtask
  task automatic strap(input logic c, input logic s0, input logic s1, input bus_type_t exp);
    conf_n = c;
    strap0 = s0;
    strap1 = s1;
    ticks(3);
    chk("bus type", 24'(exp), 24'(bus_type));
  endtask

  task automatic t_straps();
    strap(1'h0, 1'h1, 1'h0, BUS_LOCAL_SX);
    strap(1'h0, 1'h0, 1'h1, BUS_LOCAL_DX);
    strap(1'h0, 1'h1, 1'h1, BUS_LOCAL_32);
    strap(1'h1, 1'h1, 1'h1, BUS_ISA);
  endtask
  // Bit b of hit[m] says whether base b lies in the 16-bit window of display mode m.
  task automatic t_mem16();
    logic [23:0] base [4] = '{24'h0A_0000, 24'h0B_0000, 24'h0B_8000, 24'h0C_0000};
    logic [3:0]  hit [4] = '{4'h7, 4'h4, 4'h2, 4'h7};
    for (int m = 0; m < 4; m++) begin
      io16(16'h03C4, 8'h08, 8'h40 | 8'(m));
      chk("display mode", 24'(m), 24'(disp_mode));
      for (int b = 0; b < 4; b++) begin
        i_host.place(base[b]);
        ticks(1);
        chk("size16 drive", 24'(hit[m][b]), 24'(size16_oe));
      end
    end
    chk("size16 level", 24'h0, 24'(size16_n));
    io16(16'h03C4, 8'h08, 8'h00);
    i_host.place(24'h0A_0000);
    ticks(1);
    chk("size16 sole off", 24'h0, 24'(size16_oe));
    i_host.write(1'h0, 24'h00_03C5, 16'h0041);
    chk("odd port write", 24'h1, 24'(disp_mode));
    io16(16'h02C4, 8'h08, 8'h42);
    chk("foreign port", 24'h1, 24'(disp_mode));
    io16(16'h03C4, 8'h08, 8'h40);
  endtask
  task automatic t_io16();
    logic [15:0] port [12] = '{16'h03C4, 16'h03C5, 16'h03CE, 16'h03CF, 16'h03B4, 16'h03B5, 16'h03D4,
                               16'h03D5, 16'h03BA, 16'h03DA, 16'h03C0, 16'h03C6};
    for (int i = 0; i < 12; i++) begin
      i_host.place({8'h00, port[i]});
      ticks(1);
      chk("io16 claim", 24'(i < 10), 24'(claim_oe));
    end
    chk("io16 level", 24'h0, 24'(claim_n));
  endtask
  task automatic t_read();
    i_host.read_open(24'h0A_0010, 1'h1);
    ticks(6);
    chk("read request", 24'h1, 24'(rd_req));
    chk("ready waits", 24'h2, 24'({ready_oe, ready}));
    chk("bios idle", 24'h1, 24'(bios_n));
    rd_valid = 1'h1;
    ticks(1);
    rd_valid = 1'h0;
    ticks(2);
    chk("ready given", 24'h3, 24'({ready_oe, ready}));
    i_host.read_close();
    ticks(6);
    chk("ready float", 24'h0, 24'(ready_oe));
    i_host.read_open(24'h0A_0010, 1'h0);
    ticks(6);
    chk("refresh read", 24'h0, 24'({rd_req, ready_oe}));
    i_host.read_close();
    ticks(3);
    i_host.read_open(24'h0C_0000, 1'h1);
    ticks(6);
    chk("bios select", 24'h1, 24'({bios_n, bios_oe}));
    i_host.read_close();
    ticks(6);
    chk("bios release", 24'h1, 24'(bios_n));
  endtask
  task automatic t_write();
    i_host.write(1'h1, 24'h0C_0002, 16'h1234);
    chk("write refused", 24'h0, 24'(wr_req));
    i_host.write(1'h1, 24'h0A_1234, 16'h5a5a);
    chk("latch address", 24'h0A_1234, wr_addr);
    chk("latch data", 24'h00_5a5a, 24'(wr_data));
    ticks(4);
    chk("write stands", 24'h1, 24'(wr_req));
    wr_done = 1'h1;
    ticks(1);
    wr_done = 1'h0;
    ticks(1);
    chk("write taken", 24'h0, 24'(wr_req));
  endtask
  task automatic t_irq();
    io16(16'h03D4, 8'h11, 8'h10);
    vretrace = 1'h1;
    ticks(1);
    vretrace = 1'h0;
    ticks(2);
    chk("irq raised", 24'h3, 24'({irq, irq_oe}));
    io16(16'h03D4, 8'h11, 8'h00);
    chk("irq cleared", 24'h0, 24'(irq));
    io16(16'h03B4, 8'h11, 8'h30);
    chk("irq floated", 24'h0, 24'(irq_oe));
  endtask
  task automatic t_reset();
    i_host.read_open(24'h0A_0010, 1'h1);
    ticks(4);
    dev_reset = 1'h1;
    ticks(1);
    chk("reset floats", 24'h0, 24'({irq_oe, size16_oe, claim_oe, bios_oe, ready_oe}));
    dev_reset = 1'h0;
    i_host.read_close();
    ticks(4);
    chk("reset values", 24'h1, 24'({size16_oe, irq_oe}));
  endtask

  initial begin
    ticks(2);
    rst_n = 1'h1;
    ticks(2);
    t_straps();
    t_mem16();
    t_io16();
    t_read();
    t_write();
    t_irq();
    t_reset();
    give_verdict();
  end
  // The whole sequence needs well under a thousand clocks.
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
